// File: rtl/swc_codec.sv
// Card-side pulse-width bit decoder and current-return driver
// Contract
// (R01) Master sends a one as high for three quarters of period.
// (R02) Master sends a zero as high for one quarter of period.
// (R03) Ones with high time 70 to 80 percent must be accepted.
// (R04) Zeros with high time 20 to 30 percent must be accepted.
// (R05) Master sends bits back to back, no gaps.
// (R06) Each rising edge ends one bit and starts the next.
// (R07) Every bit period is measured on its own.
// (R08) Bit period 1 to 5 us, extended 0.590 to 10 us.
// (R09) Card returns data by modulating drawn current, not voltage.
// (R10) High current 600 to 1000 uA, low current 0 to 20 uA.
// (R11) Returned current is meaningful only while the line is high.
// (R12) Card changes current only while the line is low; code switches about three clocks after the pin falls.
// (R13) Decide one when high time exceeds half the period.
// (R14) Synchronise the line before edge detection and timing.
`timescale 1ns/100ps
module swc_codec
  import swc_pkg::*;
#(
  parameter int CW = CNT_W
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Link side
  input  wire logic master_voltage_line,
  output logic      slave_current_return,
  // Received bits
  output logic      rx_valid,
  output logic      rx_bit,
  output logic      rx_error,
  // Bit to return to the master
  input  wire logic tx_bit,
  output logic      tx_taken
);
  // ==========================================================
  // Input conditioning
  logic line;
  logic line_prev;

  swc_sync u_sync ( // [R14]
    .clk       (clk),
    .sys_rst   (sys_rst),
    .din       (master_voltage_line),
    .dout      (line),
    .dout_prev (line_prev)
  );

  wire rise = line & ~line_prev; // [R06]
  wire fall = ~line & line_prev;

  // ==========================================================
  // Period and high-time measurement
  swc_state_e          state;
  swc_state_e          next_state;
  logic [CW-1:0]       period_cnt;
  logic [CW-1:0]       high_cnt;

  // Both counters restart on every rising edge [R07]
  wire [CW-1:0] next_period = rise ? CNT_ONE :
                              (period_cnt == CNT_SAT) ? CNT_SAT :
                              period_cnt + CNT_ONE;
  wire [CW-1:0] next_high   = rise ? CNT_ONE :
                              (line && high_cnt != CNT_SAT) ?
                              high_cnt + CNT_ONE : high_cnt;

  // Twice the high time against the period [R13] [R03] [R04]
  wire [CW:0] high_x2   = {high_cnt, 1'b0};
  wire        dec_one   = high_x2 > {1'b0, period_cnt};
  // Out-of-range periods are flagged but still decoded [R08]
  wire        bad_per   = (period_cnt < CW'(BIT_MIN_CYC)) ||
                          (period_cnt > CW'(BIT_MAX_CYC));
  wire        bit_done  = rise && (state == SWC_LOW); // [R05]

  always_comb begin
    next_state = state;
    unique case (state)
      SWC_IDLE: if (rise) next_state = SWC_HIGH;
      SWC_HIGH: if (fall) next_state = SWC_LOW;
      SWC_LOW:  if (rise) next_state = SWC_HIGH;
      default:  next_state = SWC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state      <= SWC_IDLE;
      period_cnt <= CNT_ZERO;
      high_cnt   <= CNT_ZERO;
    end else begin
      state      <= next_state;
      period_cnt <= next_period;
      high_cnt   <= next_high;
    end
  end

  // ==========================================================
  // Decoded bit outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_valid <= 1'b0;
      rx_bit   <= 1'b0;
      rx_error <= 1'b0;
    end else begin
      rx_valid <= bit_done;
      if (bit_done) begin
        rx_bit   <= dec_one; // [R13]
        rx_error <= bad_per; // [R08]
      end
    end
  end

  // ==========================================================
  // Current return: switch only on the falling edge, so the level
  // stands across the whole next high phase the master samples.
  // Lags the pin fall by about three clocks: very short lows see it late.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slave_current_return <= 1'b0;
      tx_taken             <= 1'b0;
    end else begin
      tx_taken <= fall;
      if (fall) begin
        slave_current_return <= tx_bit; // [R09] [R10] [R11] [R12]
      end
    end
  end

  // ==========================================================
  // Checks
  chk_ret_low_only: assert property ( // [R12]
    @(posedge clk) disable iff (sys_rst)
    $changed(slave_current_return) |-> $past(fall))
    else $error("current return changed outside low phase");

  chk_ret_steady_hi: assert property ( // [R11]
    @(posedge clk) disable iff (sys_rst)
    (line && line_prev) |-> $stable(slave_current_return))
    else $error("current return moved while line high");

  chk_valid_on_rise: assert property ( // [R06]
    @(posedge clk) disable iff (sys_rst)
    (rise && state == SWC_LOW) |=> rx_valid)
    else $error("bit not reported after rising edge");

  chk_valid_cause: assert property ( // [R05]
    @(posedge clk) disable iff (sys_rst)
    rx_valid |-> $past(rise))
    else $error("bit reported without rising edge");

  chk_decide_half: assert property ( // [R13]
    @(posedge clk) disable iff (sys_rst)
    bit_done |=> (rx_bit == ($past(high_cnt) > ($past(period_cnt) >> 1))))
    else $error("decision not taken at half period");

  chk_period_restart: assert property ( // [R07]
    @(posedge clk) disable iff (sys_rst)
    rise |=> (period_cnt == CNT_ONE && high_cnt == CNT_ONE))
    else $error("counters not restarted on rising edge");

  chk_range_flag: assert property ( // [R08]
    @(posedge clk) disable iff (sys_rst)
    (bit_done && period_cnt >= CW'(BIT_MIN_CYC) &&
     period_cnt <= CW'(BIT_MAX_CYC)) |=> !rx_error)
    else $error("in-range period flagged as error");

  chk_sync_delay: assert property ( // [R14]
    @(posedge clk) disable iff (sys_rst)
    $rose(line) |-> ##1 rise == 1'b0)
    else $error("edge detector fired twice");

  chk_tx_follow: assert property ( // [R09]
    @(posedge clk) disable iff (sys_rst)
    tx_taken |-> slave_current_return == $past(tx_bit))
    else $error("returned level differs from tx_bit");

  // Pulses last one cycle, so a consumer may count them directly
  chk_valid_pulse: assert property ( // [R06]
    @(posedge clk) disable iff (sys_rst)
    rx_valid |=> !rx_valid)
    else $error("bit report longer than one cycle");

  chk_taken_pulse: assert property ( // [R12]
    @(posedge clk) disable iff (sys_rst)
    tx_taken |=> !tx_taken)
    else $error("load strobe longer than one cycle");

  chk_fall_loads: assert property ( // [R12]
    @(posedge clk) disable iff (sys_rst)
    fall |=> tx_taken)
    else $error("falling edge did not load tx_bit");

  chk_first_arms: assert property ( // [R06]
    @(posedge clk) disable iff (sys_rst)
    (rise && state == SWC_IDLE) |=> !rx_valid)
    else $error("first edge after reset reported a bit");

  chk_high_in_per: assert property ( // [R07]
    @(posedge clk) disable iff (sys_rst)
    bit_done |-> high_cnt <= period_cnt)
    else $error("high time longer than its period");

  chk_range_err: assert property ( // [R08]
    @(posedge clk) disable iff (sys_rst)
    (bit_done && (period_cnt < CW'(BIT_MIN_CYC) ||
     period_cnt > CW'(BIT_MAX_CYC))) |=> rx_error)
    else $error("out-of-range period not flagged");

  chk_high_frozen: assert property ( // [R13]
    @(posedge clk) disable iff (sys_rst)
    (state == SWC_LOW && !rise) |=> $stable(high_cnt))
    else $error("high time counted during low phase");

  cov_one:  cover property (@(posedge clk) rx_valid && rx_bit);
  cov_zero: cover property (@(posedge clk) rx_valid && !rx_bit);
  cov_err:  cover property (@(posedge clk) rx_valid && rx_error);
  cov_ret:  cover property (@(posedge clk) $rose(slave_current_return));
endmodule

// File: rtl/swc_pkg.sv
// Package: constants for the single-wire pulse-width codec receiver
package swc_pkg;
  // ==========================================================
  // Clock and timing
  localparam int CLK_FREQ_HZ      = 25_000_000;
  localparam int CLK_PERIOD_NS    = 40;
  // Bit period limits in nanoseconds (extended range covers default)
  localparam int BIT_MIN_NS       = 590;
  localparam int BIT_MAX_NS       = 10_000;
  // Least time rounds up, longest rounds down
  localparam int BIT_MIN_CYC      =
    (BIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_MAX_CYC      = BIT_MAX_NS / CLK_PERIOD_NS;
  localparam int CNT_W            = 10;
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 10'h001;
  localparam logic [CNT_W-1:0] CNT_SAT  = 10'h3FF;
  // ==========================================================
  // Receiver states
  typedef enum logic [2:0] {
    SWC_IDLE = 3'h1,
    SWC_HIGH = 3'h2,
    SWC_LOW  = 3'h4
  } swc_state_e;
endpackage

// File: rtl/swc_sync.sv
// Two-flop synchroniser with previous-value stage for edge finding
`timescale 1ns/100ps
module swc_sync
  import swc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Asynchronous input and synchronised outputs
  input  wire logic din,
  output logic      dout,
  output logic      dout_prev
);
  logic meta;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta      <= 1'b0;
      dout      <= 1'b0;
      dout_prev <= 1'b0;
    end else begin
      meta      <= din;
      dout      <= meta;
      dout_prev <= dout;
    end
  end
endmodule

// File: test/swc_master_model.sv
// Master-side line driver model for the pulse-width link
`timescale 1ns/100ps
module swc_master_model (
  // Sampling clock of the bench
  input  wire logic clk,
  // Line towards the card
  output logic      line
);
  initial line = 1'b0;
  // ==========================================
  // One bit: rise, hold high, fall, wait out the rest
  // Edges launched on the clock, so cycle counts are exact
  task automatic send_bit(input int per_cyc, input int hi_cyc);
    line <= 1'b1;
    repeat (hi_cyc) @(posedge clk);
    line <= 1'b0;
    repeat (per_cyc - hi_cyc) @(posedge clk);
  endtask
endmodule

// File: test/swc_codec_tb.sv
// Self-checking bench for the pulse-width codec receiver
`timescale 1ns/100ps
module swc_codec_tb
  import swc_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        tx_bit = 1'b0;
  logic        line;
  logic        cur, rx_valid, rx_bit, rx_error, tx_taken;
  logic [31:0] seed = 32'h99CB09B0;
  logic [31:0] tseed = 32'h99CB09B0;
  logic [1:0]  expq[$];
  int          fail_count = 0;
  int          checks_done = 0;
  int          n_sent = 0;
  int          n_taken = 0;
  int          i;
  int          cper[10] = '{640, 640, 640, 640, 9920, 9920, 9920, 9920,
                            320, 10880};
  int          cpct[10] = '{70, 80, 20, 30, 70, 80, 20, 30, 75, 25};

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  swc_master_model i_swc_master_model (
    .clk  (clk),
    .line (line)
  );
  swc_codec i_swc_codec (
    .clk                  (clk),
    .sys_rst              (sys_rst),
    .master_voltage_line  (line),
    .slave_current_return (cur),
    .rx_valid             (rx_valid),
    .rx_bit               (rx_bit),
    .rx_error             (rx_error),
    .tx_bit               (tx_bit),
    .tx_taken             (tx_taken)
  );

  // ==========================================
  // Helpers
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // Periods fall on whole clocks, so the limits map onto cycles exactly
  function automatic logic [1:0] expect_of(input int per, input int pct);
    return {per < BIT_MIN_NS || per > BIT_MAX_NS, pct > 50};
  endfunction
  task automatic cmp_cnt(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bit_out(input int per, input int pct);
    expq.push_back(expect_of(per, pct));
    n_sent++;
    i_swc_master_model.send_bit(per / CLK_PERIOD_NS,
                                per * pct / 100 / CLK_PERIOD_NS);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================
  // Monitors
  always @(posedge clk) begin
    if (rx_valid) begin
      cmp(expq.size() > 0, 1'b1);
      if (expq.size() > 0) begin
        cmp(rx_bit, expq[0][0]);
        cmp(rx_error, expq[0][1]);
        void'(expq.pop_front());
      end
    end
    if (tx_taken) begin
      cmp(cur, tx_bit);
      n_taken++;
      tseed = xorshift(tseed);
      tx_bit <= tseed[0];
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    cmp(rx_valid | tx_taken | cur, 1'b0);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 40; i++) begin
      seed = xorshift(seed);
      bit_out(320 * (2 + seed[7:0] % 30),
              seed[8] ? 70 + seed[11:9] : 20 + seed[11:9]);
    end
    $display("test random done");
    foreach (cper[k]) bit_out(cper[k], cpct[k]);
    $display("test corners done");
    // Closing bit only ends the last measured one
    i_swc_master_model.send_bit(640 / CLK_PERIOD_NS, 160 / CLK_PERIOD_NS);
    for (i = 0; i < 20 && expq.size() > 0; i++) @(posedge clk);
    if (expq.size() > 0) cmp(1'b0, 1'b1);
    cmp_cnt(n_taken, n_sent + 1);
    $display("test drain done");
    tally_and_finish();
  end
endmodule
